// ---- verilog/swbs_pkg.sv ----
// constants, field layout and command codes of the status word and bank select block
// assumes a single core clock domain; shared by the block and its bank mapping leaf
package swbs_pkg;

  // data memory locations of the block (12-bit data address)
  localparam logic [11:0] SWBS_ADDR_STATUS_LO = 12'h0fb0; // flags that software may access
  localparam logic [11:0] SWBS_ADDR_STATUS_HI = 12'h0fb1; // flags closed to memory access
  localparam logic [11:0] SWBS_ADDR_BANK_LO = 12'h0f82; // register bank selector nibble
  localparam logic [11:0] SWBS_ADDR_BANK_HI = 12'h0f83; // memory bank selector nibble

  // bit positions inside the 8-bit status word as it travels to and from the stack
  localparam int SWBS_SW_REG_BANK_EN = 0;
  localparam int SWBS_SW_MEM_BANK_EN = 1;
  localparam int SWBS_SW_LEVEL_LO = 2;
  localparam int SWBS_SW_LEVEL_HI = 3;
  localparam int SWBS_SW_SKIP_LO = 4;
  localparam int SWBS_SW_SKIP_HI = 6;
  localparam int SWBS_SW_CARRY = 7;

  // bit positions inside a vector table entry (and program memory location 0)
  localparam int SWBS_VEC_MEM_BANK_EN = 7;
  localparam int SWBS_VEC_REG_BANK_EN = 6;

  // bank select byte layout: memory bank in the upper nibble, register bank in bits 1..0
  localparam int SWBS_BSEL_MEM_LO = 4;
  localparam int SWBS_BSEL_MEM_HI = 7;
  localparam int SWBS_BSEL_REG_LO = 0;
  localparam int SWBS_BSEL_REG_HI = 1;

  // reset values
  localparam logic [3:0] SWBS_RST_MEM_BANK_SEL = 4'h0;
  localparam logic [1:0] SWBS_RST_REG_BANK_SEL = 2'h0;
  localparam logic [1:0] SWBS_RST_LEVEL = 2'h0;
  localparam logic [2:0] SWBS_RST_SKIP = 3'h0;
  localparam logic SWBS_RST_CARRY = 1'b0;

  // interrupt processing levels
  localparam logic [1:0] SWBS_LEVEL_NORMAL = 2'h0; // all interrupts accepted
  localparam logic [1:0] SWBS_LEVEL_HIGH_ONLY = 2'h1; // only higher priority accepted
  localparam logic [1:0] SWBS_LEVEL_NONE = 2'h2; // no interrupt accepted

  // memory banks that may be chosen
  localparam logic [3:0] SWBS_MEM_BANK_0 = 4'h0;
  localparam logic [3:0] SWBS_MEM_BANK_1 = 4'h1;
  localparam logic [3:0] SWBS_MEM_BANK_15 = 4'hf;

  // register bank used while register banking is off
  localparam logic [1:0] SWBS_REG_BANK_DEFAULT = 2'h0;

  // commands from the instruction execution and interrupt control logic
  typedef enum logic [4:0] {
    SWBS_CMD_NOP = 5'h00,
    SWBS_CMD_CARRY_SET = 5'h01,
    SWBS_CMD_CARRY_CLR = 5'h02,
    SWBS_CMD_BIT_INVERT = 5'h03,
    SWBS_CMD_SKIP_IF_TRUE = 5'h04,
    SWBS_CMD_BIT_LOAD = 5'h05,
    SWBS_CMD_BIT_STORE = 5'h06,
    SWBS_CMD_BIT_AND = 5'h07,
    SWBS_CMD_BIT_OR = 5'h08,
    SWBS_CMD_BIT_XOR = 5'h09,
    SWBS_CMD_ARITH_CARRY = 5'h0a,
    SWBS_CMD_MEM_BANK_CHOOSE = 5'h0b,
    SWBS_CMD_REG_BANK_CHOOSE = 5'h0c,
    SWBS_CMD_MEM_BANK_EN_SET = 5'h0d,
    SWBS_CMD_MEM_BANK_EN_CLR = 5'h0e,
    SWBS_CMD_REG_BANK_EN_SET = 5'h0f,
    SWBS_CMD_REG_BANK_EN_CLR = 5'h10,
    SWBS_CMD_CALL_SAVE = 5'h11,
    SWBS_CMD_RET_RESTORE = 5'h12,
    SWBS_CMD_INT_ENTER = 5'h13,
    SWBS_CMD_INT_RETURN = 5'h14,
    SWBS_CMD_BANK_PUSH = 5'h15,
    SWBS_CMD_BANK_POP = 5'h16
  } swbs_cmd_t;

endpackage : swbs_pkg

// ---- verilog/swbs_bank_map.sv ----
// bank mapping leaf: registers the effective data bank and general register bank
// assumes the parent hands it the next state of the enables and selectors
module swbs_bank_map
  import swbs_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // next state of the banking controls
  input wire logic mem_bank_enable_i,
  input wire logic [3:0] memory_bank_selector_i,
  input wire logic reg_bank_enable_i,
  input wire logic [1:0] register_bank_selector_i,
  // bank implied by the addressing mode when memory banking is off
  input wire logic [3:0] fixed_bank_i,
  // effective banks
  output logic [3:0] data_bank_o,
  output logic [1:0] reg_bank_o
);

  // all state of the leaf
  typedef struct packed {
    logic [3:0] data_bank; // upper four data address bits
    logic [1:0] reg_bank; // general register bank in use
  } swbs_map_t;

  swbs_map_t s; // registered state
  swbs_map_t next_s; // next state

  // choose the banks from enables and selectors
  always_comb begin
    next_s = s;
    // selector drives the upper address only while enabled, else the mode's bank
    if (mem_bank_enable_i) begin
      next_s.data_bank = memory_bank_selector_i;
    end else begin
      next_s.data_bank = fixed_bank_i;
    end
    // register bank selector ignored while banking is off
    if (reg_bank_enable_i) begin
      next_s.reg_bank = register_bank_selector_i;
    end else begin
      next_s.reg_bank = SWBS_REG_BANK_DEFAULT;
    end
  end

  // state register
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign data_bank_o = s.data_bank;
  assign reg_bank_o = s.reg_bank;

endmodule : swbs_bank_map

// ---- verilog/swbs_status_bank.sv ----
// status word and bank select registers of a 4-bit core, with stack and memory access
// assumes one command per cycle from the core and inputs synchronous to mclk_i
//
// Summary of operation
// - one carry bit holds arithmetic overflow
// - carry acts as one-bit boolean accumulator
// - carry reset value carries no meaning
// - set, clear, invert, skip on carry only
// - carry copied to or from memory bit
// - and, or, xor memory bit into carry
// - interrupt saves and restores whole status word
// - skip flags updated by execution and interrupt return
// - level codes: all, higher only, none
// - interrupt saves level then raises it
// - level readable and writable by memory access
// - memory bank enable steers upper address
// - bank enables set or cleared anytime
// - reset loads memory bank enable from rom
// - vector entry bit 7 loads memory enable
// - register bank 0 unless banking enabled
// - reset loads register bank enable from rom
// - vector entry bit 6 loads register enable
// - bank byte: memory upper, register lowest
// - memory bank 0, 1, 15, reset 0; bank pop loads any value
// - register bank 0..3, upper bits read 0
// - low status nibble only memory accessible
// - calls save only the two enables
module swbs_status_bank
  import swbs_pkg::*;
#(
  parameter int ADDR_W = 12 // data memory address width
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // command from execution and interrupt control
  input wire logic cmd_valid_i,
  input wire swbs_cmd_t cmd_i,
  input wire logic mem_bit_i, // selected data memory bit
  input wire logic arith_carry_i, // carry out of add or subtract with carry
  input wire logic [3:0] sel_value_i, // bank number for the choose commands
  input wire logic [7:0] vector_byte_i, // vector entry, or location 0 after reset
  input wire logic [7:0] stack_data_i, // byte popped from the stack
  // skip state from the execution logic
  input wire logic skip_update_i,
  input wire logic [2:0] skip_state_i,
  // addressing mode bank while memory banking is off
  input wire logic [3:0] fixed_bank_i,
  // data memory access to the block's nibbles
  input wire logic [ADDR_W-1:0] mem_addr_i,
  input wire logic mem_rd_i,
  input wire logic mem_wr_i,
  input wire logic [3:0] mem_wdata_i,
  output logic [3:0] mem_rdata_o,
  output logic mem_rvalid_o,
  // stack push
  output logic stack_push_o,
  output logic [7:0] stack_data_o,
  // bit transfer toward memory
  output logic mem_bit_we_o,
  output logic mem_bit_o,
  // skip request from the carry test
  output logic skip_o,
  // status toward the core
  output logic carry_o,
  output logic [2:0] skip_state_o,
  output logic [1:0] int_level_o,
  output logic mem_bank_enable_o,
  output logic reg_bank_enable_o,
  output logic [3:0] memory_bank_selector_o,
  output logic [1:0] register_bank_selector_o,
  // effective banks
  output logic [3:0] data_bank_o,
  output logic [1:0] reg_bank_o
);

  // refuse address widths that cannot reach the block's locations
  if (ADDR_W != 12) begin : g_bad_width
    $error("swbs_status_bank: ADDR_W must be 12");
  end

  // all state of the block
  typedef struct packed {
    logic carry_bit; // carry and bit accumulator
    logic [2:0] skip_state; // skip status from execution
    logic [1:0] int_level; // interrupt processing level
    logic mem_bank_enable; // memory banking on
    logic reg_bank_enable; // register banking on
    logic [3:0] memory_bank_selector; // chosen memory bank
    logic [1:0] register_bank_selector; // chosen register bank
    logic boot; // first cycle after reset release
    logic [3:0] rdata; // memory read data
    logic rvalid; // memory read answer pulse
    logic push; // stack push pulse
    logic [7:0] push_data; // byte pushed
    logic bit_we; // memory bit write pulse
    logic bit_out; // memory bit write value
    logic skip; // skip request pulse
  } swbs_state_t;

  swbs_state_t s; // registered state
  swbs_state_t next_s; // next state
  logic [7:0] status_word; // current status word as a byte
  logic [7:0] bank_byte; // current bank select byte
  logic [ADDR_W-1:0] addr_status_lo; // address constants at port width
  logic [ADDR_W-1:0] addr_bank_lo;
  logic [ADDR_W-1:0] addr_bank_hi;

  assign addr_status_lo = SWBS_ADDR_STATUS_LO[ADDR_W-1:0];
  assign addr_bank_lo = SWBS_ADDR_BANK_LO[ADDR_W-1:0];
  assign addr_bank_hi = SWBS_ADDR_BANK_HI[ADDR_W-1:0];

  // assemble the status word in its stack layout
  always_comb begin
    status_word = 8'h00;
    status_word[SWBS_SW_CARRY] = s.carry_bit;
    status_word[SWBS_SW_SKIP_HI:SWBS_SW_SKIP_LO] = s.skip_state;
    status_word[SWBS_SW_LEVEL_HI:SWBS_SW_LEVEL_LO] = s.int_level;
    status_word[SWBS_SW_MEM_BANK_EN] = s.mem_bank_enable;
    status_word[SWBS_SW_REG_BANK_EN] = s.reg_bank_enable;
  end

  // assemble the bank select byte; bits 3..2 stay zero
  always_comb begin
    bank_byte = 8'h00;
    bank_byte[SWBS_BSEL_MEM_HI:SWBS_BSEL_MEM_LO] = s.memory_bank_selector;
    bank_byte[SWBS_BSEL_REG_HI:SWBS_BSEL_REG_LO] = s.register_bank_selector;
  end

  // next state: pulses fall, then memory access, then the command
  always_comb begin
    next_s = s;
    next_s.rvalid = 1'b0;
    next_s.push = 1'b0;
    next_s.bit_we = 1'b0;
    next_s.skip = 1'b0;
    next_s.boot = 1'b0;

    // first cycle after reset: enables from program memory location 0
    if (s.boot) begin
      next_s.mem_bank_enable = vector_byte_i[SWBS_VEC_MEM_BANK_EN];
      next_s.reg_bank_enable = vector_byte_i[SWBS_VEC_REG_BANK_EN];
    end

    // skip flags follow execution and have no writable operand
    if (skip_update_i) begin
      next_s.skip_state = skip_state_i;
    end

    // memory read of the block's nibbles; answer one cycle later
    if (mem_rd_i) begin
      next_s.rvalid = 1'b1;
      if (mem_addr_i == addr_status_lo) begin
        next_s.rdata = status_word[3:0];
      end else if (mem_addr_i == addr_bank_lo) begin
        next_s.rdata = bank_byte[3:0];
      end else if (mem_addr_i == addr_bank_hi) begin
        next_s.rdata = bank_byte[7:4];
      end else begin
        next_s.rdata = 4'h0; // upper status nibble and other addresses read zero
      end
    end

    // memory write; upper status nibble is not writable
    if (mem_wr_i) begin
      if (mem_addr_i == addr_status_lo) begin
        next_s.int_level = mem_wdata_i[SWBS_SW_LEVEL_HI:SWBS_SW_LEVEL_LO];
        next_s.mem_bank_enable = mem_wdata_i[SWBS_SW_MEM_BANK_EN];
        next_s.reg_bank_enable = mem_wdata_i[SWBS_SW_REG_BANK_EN];
      end else if (mem_addr_i == addr_bank_lo) begin
        next_s.register_bank_selector = mem_wdata_i[1:0];
      end else if (mem_addr_i == addr_bank_hi) begin
        // only banks 0, 1 and 15 are taken
        if (mem_wdata_i == SWBS_MEM_BANK_0 || mem_wdata_i == SWBS_MEM_BANK_1 ||
            mem_wdata_i == SWBS_MEM_BANK_15) begin
          next_s.memory_bank_selector = mem_wdata_i;
        end
      end
    end

    // command from the core
    if (cmd_valid_i) begin
      unique case (cmd_i)
        SWBS_CMD_NOP: begin
        end
        // dedicated carry operations leave all other bits alone
        SWBS_CMD_CARRY_SET: begin
          next_s.carry_bit = 1'b1;
        end
        SWBS_CMD_CARRY_CLR: begin
          next_s.carry_bit = 1'b0;
        end
        SWBS_CMD_BIT_INVERT: begin
          next_s.carry_bit = ~s.carry_bit;
        end
        SWBS_CMD_SKIP_IF_TRUE: begin
          next_s.skip = s.carry_bit;
        end
        // bit transfer
        SWBS_CMD_BIT_LOAD: begin
          next_s.carry_bit = mem_bit_i;
        end
        SWBS_CMD_BIT_STORE: begin
          next_s.bit_we = 1'b1;
          next_s.bit_out = s.carry_bit;
        end
        // boolean accumulate into the carry
        SWBS_CMD_BIT_AND: begin
          next_s.carry_bit = s.carry_bit & mem_bit_i;
        end
        SWBS_CMD_BIT_OR: begin
          next_s.carry_bit = s.carry_bit | mem_bit_i;
        end
        SWBS_CMD_BIT_XOR: begin
          next_s.carry_bit = s.carry_bit ^ mem_bit_i;
        end
        // add or subtract with carry
        SWBS_CMD_ARITH_CARRY: begin
          next_s.carry_bit = arith_carry_i;
        end
        // bank choice; unsupported memory banks ignored
        SWBS_CMD_MEM_BANK_CHOOSE: begin
          if (sel_value_i == SWBS_MEM_BANK_0 || sel_value_i == SWBS_MEM_BANK_1 ||
              sel_value_i == SWBS_MEM_BANK_15) begin
            next_s.memory_bank_selector = sel_value_i;
          end
        end
        SWBS_CMD_REG_BANK_CHOOSE: begin
          next_s.register_bank_selector = sel_value_i[1:0];
        end
        // enables by bit instruction, whatever bank is chosen
        SWBS_CMD_MEM_BANK_EN_SET: begin
          next_s.mem_bank_enable = 1'b1;
        end
        SWBS_CMD_MEM_BANK_EN_CLR: begin
          next_s.mem_bank_enable = 1'b0;
        end
        SWBS_CMD_REG_BANK_EN_SET: begin
          next_s.reg_bank_enable = 1'b1;
        end
        SWBS_CMD_REG_BANK_EN_CLR: begin
          next_s.reg_bank_enable = 1'b0;
        end
        // call pushes the two enables only, others zero
        SWBS_CMD_CALL_SAVE: begin
          next_s.push = 1'b1;
          next_s.push_data = 8'h00;
          next_s.push_data[SWBS_SW_MEM_BANK_EN] = s.mem_bank_enable;
          next_s.push_data[SWBS_SW_REG_BANK_EN] = s.reg_bank_enable;
        end
        SWBS_CMD_RET_RESTORE: begin
          next_s.mem_bank_enable = stack_data_i[SWBS_SW_MEM_BANK_EN];
          next_s.reg_bank_enable = stack_data_i[SWBS_SW_REG_BANK_EN];
        end
        // interrupt entry: push whole word, raise level, enables from vector
        SWBS_CMD_INT_ENTER: begin
          next_s.push = 1'b1;
          next_s.push_data = status_word;
          unique case (s.int_level)
            SWBS_LEVEL_NORMAL: next_s.int_level = SWBS_LEVEL_HIGH_ONLY;
            SWBS_LEVEL_HIGH_ONLY: next_s.int_level = SWBS_LEVEL_NONE;
            default: next_s.int_level = SWBS_LEVEL_NONE;
          endcase
          next_s.mem_bank_enable = vector_byte_i[SWBS_VEC_MEM_BANK_EN];
          next_s.reg_bank_enable = vector_byte_i[SWBS_VEC_REG_BANK_EN];
        end
        // interrupt return: whole word back at once
        SWBS_CMD_INT_RETURN: begin
          next_s.carry_bit = stack_data_i[SWBS_SW_CARRY];
          next_s.skip_state = stack_data_i[SWBS_SW_SKIP_HI:SWBS_SW_SKIP_LO];
          next_s.int_level = stack_data_i[SWBS_SW_LEVEL_HI:SWBS_SW_LEVEL_LO];
          next_s.mem_bank_enable = stack_data_i[SWBS_SW_MEM_BANK_EN];
          next_s.reg_bank_enable = stack_data_i[SWBS_SW_REG_BANK_EN];
        end
        // bank select byte as one unit
        SWBS_CMD_BANK_PUSH: begin
          next_s.push = 1'b1;
          next_s.push_data = bank_byte;
        end
        SWBS_CMD_BANK_POP: begin
          next_s.memory_bank_selector = stack_data_i[SWBS_BSEL_MEM_HI:SWBS_BSEL_MEM_LO];
          next_s.register_bank_selector = stack_data_i[SWBS_BSEL_REG_HI:SWBS_BSEL_REG_LO];
        end
        default: begin
        end
      endcase
    end
  end

  // state register; carry reset value is a convenience only
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
      s.carry_bit <= SWBS_RST_CARRY;
      s.skip_state <= SWBS_RST_SKIP;
      s.int_level <= SWBS_RST_LEVEL;
      s.memory_bank_selector <= SWBS_RST_MEM_BANK_SEL;
      s.register_bank_selector <= SWBS_RST_REG_BANK_SEL;
      s.boot <= 1'b1; // enables taken from location 0 after release
    end else begin
      s <= next_s;
    end
  end

  // effective banks from the next state so they track the registers
  swbs_bank_map u_bank_map (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .mem_bank_enable_i(next_s.mem_bank_enable),
    .memory_bank_selector_i(next_s.memory_bank_selector),
    .reg_bank_enable_i(next_s.reg_bank_enable),
    .register_bank_selector_i(next_s.register_bank_selector),
    .fixed_bank_i(fixed_bank_i),
    .data_bank_o(data_bank_o),
    .reg_bank_o(reg_bank_o)
  );

  // outputs straight from the state register
  assign mem_rdata_o = s.rdata;
  assign mem_rvalid_o = s.rvalid;
  assign stack_push_o = s.push;
  assign stack_data_o = s.push_data;
  assign mem_bit_we_o = s.bit_we;
  assign mem_bit_o = s.bit_out;
  assign skip_o = s.skip;
  assign carry_o = s.carry_bit;
  assign skip_state_o = s.skip_state;
  assign int_level_o = s.int_level;
  assign mem_bank_enable_o = s.mem_bank_enable;
  assign reg_bank_enable_o = s.reg_bank_enable;
  assign memory_bank_selector_o = s.memory_bank_selector;
  assign register_bank_selector_o = s.register_bank_selector;

endmodule : swbs_status_bank

// ---- dv/swbs_status_bank_assertions.sv ----
// checker for the status word and bank select block
// assumes it is bound to swbs_status_bank and sees only its ports
module swbs_status_bank_checker
  import swbs_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // command and memory inputs
  input wire logic cmd_valid_i,
  input wire swbs_cmd_t cmd_i,
  input wire logic mem_bit_i,
  input wire logic [3:0] sel_value_i,
  input wire logic mem_rd_i,
  input wire logic mem_wr_i,
  // observed outputs
  input wire logic mem_rvalid_o,
  input wire logic stack_push_o,
  input wire logic [7:0] stack_data_o,
  input wire logic mem_bit_we_o,
  input wire logic mem_bit_o,
  input wire logic skip_o,
  input wire logic carry_o,
  input wire logic [2:0] skip_state_o,
  input wire logic [1:0] int_level_o,
  input wire logic mem_bank_enable_o,
  input wire logic reg_bank_enable_o,
  input wire logic [3:0] memory_bank_selector_o,
  input wire logic [1:0] register_bank_selector_o,
  input wire logic [3:0] data_bank_o,
  input wire logic [1:0] reg_bank_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // one clock domain, one reset
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  a_skip_on_carry: assert property (cmd_valid_i && cmd_i == SWBS_CMD_SKIP_IF_TRUE
    |=> skip_o == $past(carry_o)) else $error("skip pulse differs from carry");
  a_carry_set_one: assert property (cmd_valid_i && cmd_i == SWBS_CMD_CARRY_SET
    |=> carry_o) else $error("carry not set");
  a_bit_store_copy: assert property (cmd_valid_i && cmd_i == SWBS_CMD_BIT_STORE
    |=> mem_bit_we_o && mem_bit_o == $past(carry_o)) else $error("bit store wrong");
  a_bit_and_acc: assert property (cmd_valid_i && cmd_i == SWBS_CMD_BIT_AND
    |=> carry_o == $past(carry_o & mem_bit_i)) else $error("and into carry wrong");
  a_int_push_word: assert property (cmd_valid_i && cmd_i == SWBS_CMD_INT_ENTER
    |=> stack_push_o && stack_data_o == $past({carry_o, skip_state_o, int_level_o,
    mem_bank_enable_o, reg_bank_enable_o})) else $error("interrupt push word wrong");
  a_level_step_up: assert property (cmd_valid_i && cmd_i == SWBS_CMD_INT_ENTER
    |=> int_level_o == ($past(int_level_o) == 2'h0 ? 2'h1 : 2'h2))
    else $error("level step wrong");
  a_read_answer: assert property (mem_rd_i |=> mem_rvalid_o)
    else $error("read not answered");
  a_bad_bank_kept: assert property (cmd_valid_i && cmd_i == SWBS_CMD_MEM_BANK_CHOOSE
    && !(sel_value_i inside {4'h0, 4'h1, 4'hf}) && !mem_wr_i
    |=> $stable(memory_bank_selector_o)) else $error("invalid bank accepted");
  a_data_bank_sel: assert property (mem_bank_enable_o
    |-> data_bank_o == memory_bank_selector_o) else $error("data bank wrong");
  a_reg_bank_sel: assert property (reg_bank_o == (reg_bank_enable_o ?
    register_bank_selector_o : 2'h0)) else $error("register bank wrong");
endmodule : swbs_status_bank_checker

bind swbs_status_bank swbs_status_bank_checker u_swbs_status_bank_checker (
  .mclk_i, .rst_i, .cmd_valid_i, .cmd_i, .mem_bit_i, .sel_value_i, .mem_rd_i, .mem_wr_i,
  .mem_rvalid_o, .stack_push_o, .stack_data_o, .mem_bit_we_o, .mem_bit_o, .skip_o,
  .carry_o, .skip_state_o, .int_level_o, .mem_bank_enable_o, .reg_bank_enable_o,
  .memory_bank_selector_o, .register_bank_selector_o, .data_bank_o, .reg_bank_o
);

// ---- dv/swbs_stack_model.sv ----
// stack memory model of the core: takes pushed bytes, offers the top for pops
// assumes a pop is never issued at the edge that captures a push
module swbs_stack_model (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // push side
  input wire logic push_i,
  input wire logic [7:0] push_data_i,
  // pop side
  input wire logic pop_i,
  output logic [7:0] top_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [16]; // stack bytes
  logic [3:0] sp; // entries held
  logic [7:0] last; // last byte offered
  // last in, first out; a whole byte per entry
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sp <= 4'h0;
      last <= 8'h00;
    end else if (push_i) begin
      mem[sp] <= push_data_i;
      sp <= sp + 4'h1;
    end else if (pop_i && sp != 4'h0) begin
      last <= mem[sp - 4'h1];
      sp <= sp - 4'h1;
    end
  end
  // empty stack shows the inverse of the last value, never a stale copy
  always_comb begin
    top_o = (sp == 4'h0) ? ~last : mem[sp - 4'h1];
  end
endmodule : swbs_stack_model

// ---- dv/testbench.sv ----
// self-checking bench of the status word and bank select block
// assumes inputs change 1 ns after the rising edge and results show one edge later
module testbench;
  import swbs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
  int fails = 0;
  int num_checks = 0;
  logic mclk_i = 0, rst_i = 1, cmd_valid_i = 0, mem_bit_i = 0, arith_carry_i = 0;
  swbs_cmd_t cmd_i = SWBS_CMD_NOP;
  logic [3:0] sel_value_i = 4'h0, fixed_bank_i = 4'h0, mem_wdata_i = 4'h0, mem_rdata_o;
  logic [7:0] vector_byte_i = 8'h80, stack_data_i, stack_data_o;
  logic skip_update_i = 0, mem_rd_i = 0, mem_wr_i = 0, mem_rvalid_o, stack_push_o;
  logic [2:0] skip_state_i = 3'h0, skip_state_o;
  logic [11:0] mem_addr_i = 12'h000;
  logic mem_bit_we_o, mem_bit_o, skip_o, carry_o, mem_bank_enable_o, reg_bank_enable_o;
  logic [1:0] int_level_o, register_bank_selector_o, reg_bank_o;
  logic [3:0] memory_bank_selector_o, data_bank_o;
  wire pop = cmd_valid_i && cmd_i inside {SWBS_CMD_RET_RESTORE, SWBS_CMD_INT_RETURN,
    SWBS_CMD_BANK_POP};
  wire [7:0] sw = {carry_o, skip_state_o, int_level_o, mem_bank_enable_o, reg_bank_enable_o};
  always #5 mclk_i = ~mclk_i;

  swbs_status_bank u_swbs_status_bank (.mclk_i, .rst_i, .cmd_valid_i, .cmd_i, .mem_bit_i,
    .arith_carry_i, .sel_value_i, .vector_byte_i, .stack_data_i, .skip_update_i,
    .skip_state_i, .fixed_bank_i, .mem_addr_i, .mem_rd_i, .mem_wr_i, .mem_wdata_i,
    .mem_rdata_o, .mem_rvalid_o, .stack_push_o, .stack_data_o, .mem_bit_we_o, .mem_bit_o,
    .skip_o, .carry_o, .skip_state_o, .int_level_o, .mem_bank_enable_o, .reg_bank_enable_o,
    .memory_bank_selector_o, .register_bank_selector_o, .data_bank_o, .reg_bank_o);
  swbs_stack_model u_swbs_stack_model (.mclk_i, .rst_i, .push_i(stack_push_o),
    .push_data_i(stack_data_o), .pop_i(pop), .top_o(stack_data_i));

  // one edge, then inputs may change again
  task step(); @(posedge mclk_i); #1; endtask : step
  // drop the command and memory strobes; back to back transfers of one kind keep theirs up
  task idle();
    cmd_valid_i = 0; cmd_i = SWBS_CMD_NOP; mem_wr_i = 0; mem_rd_i = 0;
  endtask : idle
  // one command cycle; the next transfer or idle() lowers the strobe
  task cmd(input swbs_cmd_t c, input logic [3:0] v);
    mem_wr_i = 0; mem_rd_i = 0;
    cmd_valid_i = 1; cmd_i = c; sel_value_i = v; mem_bit_i = v[0]; arith_carry_i = v[0];
    step();
  endtask : cmd
  // one nibble write or read cycle; strobes stay up until the next transfer
  task mem(input logic wr, input logic [11:0] a, input logic [3:0] d);
    cmd_valid_i = 0; cmd_i = SWBS_CMD_NOP;
    mem_addr_i = a; mem_wdata_i = d; mem_wr_i = wr; mem_rd_i = !wr;
    step();
  endtask : mem

  // carry ops in a row, each result from the previous one
  task automatic carry_ops();
    swbs_cmd_t c[9] = '{SWBS_CMD_CARRY_SET, SWBS_CMD_CARRY_CLR, SWBS_CMD_BIT_INVERT,
      SWBS_CMD_BIT_AND, SWBS_CMD_BIT_OR, SWBS_CMD_BIT_XOR, SWBS_CMD_BIT_LOAD,
      SWBS_CMD_ARITH_CARRY, SWBS_CMD_ARITH_CARRY};
    logic [8:0] b = 9'b110110000, e = 9'b110010101;
    for (int i = 0; i < 9; i++) begin
      cmd(c[i], {3'h0, b[i]});
      `CHK(carry_o, e[i])
    end
    cmd(SWBS_CMD_SKIP_IF_TRUE, 4'h0);
    `CHK(skip_o, 1'b1)
    cmd(SWBS_CMD_BIT_STORE, 4'h0);
    `CHK({mem_bit_we_o, mem_bit_o}, 2'b11)
    cmd(SWBS_CMD_CARRY_CLR, 4'h0);
    cmd(SWBS_CMD_SKIP_IF_TRUE, 4'h0);
    `CHK(skip_o, 1'b0)
    cmd(SWBS_CMD_CARRY_SET, 4'h0);
  endtask : carry_ops

  // nested entries then returns through the stack model
  task automatic int_nest();
    logic [7:0] v[3] = '{8'h40, 8'h80, 8'h00}, w[4] = '{8'hd2, 8'hd5, 8'hda, 8'hd8};
    idle();
    skip_update_i = 1; skip_state_i = 3'h5; step(); skip_update_i = 0;
    `CHK(skip_state_o, 3'h5)
    for (int i = 0; i < 3; i++) begin
      vector_byte_i = v[i]; cmd(SWBS_CMD_INT_ENTER, 4'h0);
      `CHK({stack_push_o, stack_data_o}, {1'b1, w[i]})
      `CHK(sw, w[i + 1])
      idle();
      step();
    end
    for (int i = 2; i >= 0; i--) begin
      cmd(SWBS_CMD_INT_RETURN, 4'h0);
      `CHK(sw, w[i])
    end
  endtask : int_nest

  // nibble access to status and bank locations
  task mem_access();
    mem(1, SWBS_ADDR_STATUS_LO, 4'hb);
    `CHK(sw, 8'hdb)
    mem(0, SWBS_ADDR_STATUS_LO, 4'h0);
    `CHK({mem_rvalid_o, mem_rdata_o}, 5'h1b)
    mem(1, SWBS_ADDR_STATUS_HI, 4'h0);
    mem(0, SWBS_ADDR_STATUS_HI, 4'h0);
    `CHK({mem_rvalid_o, mem_rdata_o, sw}, 13'h10db)
    mem(1, SWBS_ADDR_BANK_HI, 4'hf);
    mem(1, SWBS_ADDR_BANK_HI, 4'h2);
    mem(1, SWBS_ADDR_BANK_LO, 4'hf);
    mem(0, SWBS_ADDR_BANK_LO, 4'h0);
    `CHK({mem_rvalid_o, mem_rdata_o, data_bank_o, reg_bank_o}, 11'h4ff)
    mem(0, 12'h123, 4'h0);
    `CHK({mem_rvalid_o, mem_rdata_o}, 5'h10)
    fixed_bank_i = 4'hf;
    cmd(SWBS_CMD_REG_BANK_EN_CLR, 4'h0);
    cmd(SWBS_CMD_MEM_BANK_EN_CLR, 4'h0);
    `CHK({data_bank_o, reg_bank_o}, 6'h3c)
  endtask : mem_access

  // call save and return, bank byte push and pop
  task call_bank();
    cmd(SWBS_CMD_MEM_BANK_EN_SET, 4'h0);
    cmd(SWBS_CMD_REG_BANK_EN_SET, 4'h0);
    cmd(SWBS_CMD_CALL_SAVE, 4'h0);
    `CHK({stack_push_o, stack_data_o}, 9'h103)
    cmd(SWBS_CMD_REG_BANK_EN_CLR, 4'h0);
    cmd(SWBS_CMD_CARRY_CLR, 4'h0);
    cmd(SWBS_CMD_RET_RESTORE, 4'h0);
    `CHK(sw, 8'h5b)
    cmd(SWBS_CMD_BANK_PUSH, 4'h0);
    `CHK({stack_push_o, stack_data_o}, 9'h1f3)
    cmd(SWBS_CMD_MEM_BANK_CHOOSE, 4'h1);
    cmd(SWBS_CMD_MEM_BANK_CHOOSE, 4'h7);
    cmd(SWBS_CMD_REG_BANK_CHOOSE, 4'h2);
    `CHK({memory_bank_selector_o, register_bank_selector_o, reg_bank_o}, 8'h1a)
    cmd(SWBS_CMD_BANK_POP, 4'h0);
    `CHK({memory_bank_selector_o, register_bank_selector_o}, 6'h3f)
  endtask : call_bank

  // verdict and end of run
  task stop_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test

  initial begin
    repeat (16) @(posedge mclk_i);
    #1 rst_i = 0;
    step();
    `CHK({sw[1:0], memory_bank_selector_o, register_bank_selector_o}, 8'h80)
    carry_ops();
    int_nest();
    mem_access();
    call_bank();
    stop_test();
  end
endmodule : testbench
